// ===== include/tsa_defs.vh
/*
  Constants for the timeslot assigner: register indices, field positions,
  reset value and frame timing.
  Assumes inclusion by bare name from hw/ sources.
*/
`ifndef TSA_DEFS_VH
`define TSA_DEFS_VH

// ----------------------------------------
// Register word offsets (wb_adr_i bits 5:2)
// ----------------------------------------
`define TSA_A_OUT_B1      4'h0
`define TSA_A_OUT_B2      4'h1
`define TSA_A_OUT_D       4'h2
`define TSA_A_IN_B1       4'h3
`define TSA_A_IN_B2       4'h4
`define TSA_A_IN_D        4'h5
`define TSA_A_CTRL        4'h6
`define TSA_A_CFG2        4'h7
`define TSA_A_OVSEL       4'h8
`define TSA_A_M4TX        4'h9
`define TSA_A_STAT        4'ha
`define TSA_ADDR_LSB      2
`define TSA_ADDR_MSB      5

// ----------------------------------------
// Fields
// ----------------------------------------
`define TSA_RESET_VAL     8'h00
`define TSA_B_EN_B1       7
`define TSA_B_EN_B2       6
`define TSA_B_EN_D        5
`define TSA_B_M4SRC       4
`define TSA_B_GCI         3
`define TSA_B_DPORT       0
`define TSA_B_OVL         0
`define TSA_B_GSLOT_HI    2

// ----------------------------------------
// Framing
// ----------------------------------------
`define TSA_BITS_PER_SLOT 1'b1
`define TSA_FIELD_A_W    8'h04
`define TSA_CH_BITS       3'h7
`define TSA_D_BITS        3'h1

`endif

// ===== hw/tsa_timeslot_assigner.v
/*
  Timeslot assigner for a serial 2B+D bus: register file on classic
  Wishbone, slot counter driven by sampled bit clock and frame sync,
  channel placement on the serial output and input, D-channel port and
  M4 bit sourcing.
  Assumes serial_bit_clock and frame syncs are slow against clk_i
  (bit clock 800 ns, clk_i 100 ns) and that the far end keeps
  to the serial bus framing.
*/
// The register offsets and the Wishbone register port were decided locally.
// Function
// - Register holds output timeslot of B1 on serial output.
// - Register holds output timeslot of B2 on serial output.
// - Register holds output timeslot of D on serial output.
// - Register holds input sampling timeslot of B1.
// - Register holds input sampling timeslot of B2.
// - Register holds input timeslot of D; low bits are Field_a field.
// - Slot and control registers clear on hardware or software reset.
// - Any channel enable puts all three channels in assigner mode.
// - Assigner mode ignores 8/10 format bit, uses programmed slots only.
// - Disabled channel absent from output; its line transmit data held high, except line D, which takes the D port while the port is on.
// - D enable with D port: D to both outputs, line D from port.
// - D port without D enable: D on port, serial output floats.
// - D port clock is timed from receive frame sync at D slot, from GCI frame sync in GCI-over-bus mode.
// - GCI select uses 3-bit slot field decoded like slot pins.
// - Full GCI, M4 source 0: C/I sets activation M4 bits.
// - Full GCI NT, M4 source 0: ps1, ps2 follow power pins.
// - M4 source 1: all M4 bits come from M4 transmit register.
// - M4 source bit writable via monitor commands in full GCI.
// - Host pin and GCI enable carry 2B+D in Field_a.
// - GCI-over-bus ignores monitor and C/I inputs, leaves them undriven.
// - GCI frame sync overrides superframe align input in this mode.
// - Timeslots are two bit clocks wide, numbered from zero.
// - Overlay registers hidden until overlay access bit is set.
`timescale 1ns/1ps
`include "tsa_defs.vh"

module tsa_timeslot_assigner (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       soft_rst_i,
  // Wishbone slave
  input  wire       wb_cyc_i,
  input  wire       wb_stb_i,
  input  wire       wb_we_i,
  input  wire [5:0] wb_adr_i,
  input  wire [3:0] wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg        wb_ack_o,
  // Serial bus pins
  input  wire       serial_bit_clock_i,
  input  wire       receive_frame_sync_i,
  input  wire       gci_frame_sync_i,
  input  wire       serial_din_i,
  output reg        serial_dout_o,
  output reg        serial_dout_oe_o,
  // D-channel port
  input  wire       dport_data_in_i,
  output reg        dport_data_out_o,
  output reg        dport_clock_out_o,
  // Mode and status pins
  input  wire       host_mode_pin_i,
  input  wire       lt_mode_i,
  input  wire       tx_superframe_align_in_i,
  input  wire       power_status_in_one_i,
  input  wire       power_status_in_two_i,
  input  wire       ci_act_i,
  input  wire       ci_dea_i,
  input  wire       ci_uoa_i,
  input  wire       ci_sai_i,
  input  wire       mon_m4src_wr_i,
  input  wire       mon_m4src_val_i,
  // Line side data
  input  wire [7:0] line_b1_rx_i,
  input  wire [7:0] line_b2_rx_i,
  input  wire [1:0] line_d_rx_i,
  output reg  [7:0] line_b1_tx_o,
  output reg  [7:0] line_b2_tx_o,
  output reg  [1:0] line_d_tx_o,
  output reg  [7:0] m4_tx_bits_o,
  output reg        tx_superframe_start_o,
  output reg        assign_mode_o,
  output reg  [7:0] field_a_o
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] out_b1_slot_q, out_b2_slot_q, out_d_slot_q;
  reg [7:0] in_b1_slot_q, in_b2_slot_q, in_d_and_field_a_q;
  reg [7:0] slot_assign_control_q;
  reg [7:0] config_two_register_q;
  reg [7:0] overlay_select_register_q;
  reg [7:0] m4_transmit_register_q;
  reg [7:0] slot_cnt_q;

  wire       clr        = rst_i | soft_rst_i;
  wire [3:0] widx       = wb_adr_i[`TSA_ADDR_MSB:`TSA_ADDR_LSB];
  wire       ovl        = overlay_select_register_q[`TSA_B_OVL];
  wire       wr         = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];

  // Overlay words only decode while access bit is set
  function is_overlay;
    input [3:0] a;
    begin
      is_overlay = (a <= `TSA_A_CFG2);
    end
  endfunction

  wire ov_ok = ~is_overlay(widx) | ovl;

  always @(posedge clk_i) begin
    if (clr) begin
      out_b1_slot_q             <= `TSA_RESET_VAL;
      out_b2_slot_q             <= `TSA_RESET_VAL;
      out_d_slot_q              <= `TSA_RESET_VAL;
      in_b1_slot_q              <= `TSA_RESET_VAL;
      in_b2_slot_q              <= `TSA_RESET_VAL;
      in_d_and_field_a_q       <= `TSA_RESET_VAL;
      slot_assign_control_q     <= `TSA_RESET_VAL;
      config_two_register_q     <= `TSA_RESET_VAL;
      overlay_select_register_q <= `TSA_RESET_VAL;
      m4_transmit_register_q    <= `TSA_RESET_VAL;
    end else begin
      if (wr && ov_ok) begin
        case (widx)
          `TSA_A_OUT_B1: out_b1_slot_q             <= wb_dat_i[7:0];
          `TSA_A_OUT_B2: out_b2_slot_q             <= wb_dat_i[7:0];
          `TSA_A_OUT_D:  out_d_slot_q              <= wb_dat_i[7:0];
          `TSA_A_IN_B1:  in_b1_slot_q              <= wb_dat_i[7:0];
          `TSA_A_IN_B2:  in_b2_slot_q              <= wb_dat_i[7:0];
          `TSA_A_IN_D:   in_d_and_field_a_q       <= wb_dat_i[7:0];
          `TSA_A_CTRL:   slot_assign_control_q     <= wb_dat_i[7:0];
          `TSA_A_CFG2:   config_two_register_q     <= wb_dat_i[7:0];
          `TSA_A_OVSEL:  overlay_select_register_q <= wb_dat_i[7:0];
          `TSA_A_M4TX:   m4_transmit_register_q    <= wb_dat_i[7:0];
          default: ;
        endcase
      end
      // Monitor command in full GCI; applied after the bus write
      if (mon_m4src_wr_i && !host_mode_pin_i)
        slot_assign_control_q[`TSA_B_M4SRC] <= mon_m4src_val_i;
    end
  end

  // ----------------------------------------
  // Wishbone answer: ack one cycle after request, unmapped reads zero
  // ----------------------------------------
  reg [7:0] rd_d;
  always @* begin
    rd_d = `TSA_RESET_VAL;
    if (ov_ok) begin
      case (widx)
        `TSA_A_OUT_B1: rd_d = out_b1_slot_q;
        `TSA_A_OUT_B2: rd_d = out_b2_slot_q;
        `TSA_A_OUT_D:  rd_d = out_d_slot_q;
        `TSA_A_IN_B1:  rd_d = in_b1_slot_q;
        `TSA_A_IN_B2:  rd_d = in_b2_slot_q;
        `TSA_A_IN_D:   rd_d = in_d_and_field_a_q;
        `TSA_A_CTRL:   rd_d = slot_assign_control_q;
        `TSA_A_CFG2:   rd_d = config_two_register_q;
        `TSA_A_OVSEL:  rd_d = overlay_select_register_q;
        `TSA_A_M4TX:   rd_d = m4_transmit_register_q;
        `TSA_A_STAT:   rd_d = slot_cnt_q;
        default:       rd_d = `TSA_RESET_VAL;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= {24'h00_0000, rd_d};
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [5:0] s1_q, s2_q;
  reg       bclk_prev_q;
  reg       fs_prev_q;
  wire [5:0] pins = {dport_data_in_i, serial_bit_clock_i, receive_frame_sync_i, gci_frame_sync_i,
                     serial_din_i, tx_superframe_align_in_i};

  // ----------------------------------------
  // Modes
  // ----------------------------------------
  wire en_b1  = slot_assign_control_q[`TSA_B_EN_B1];
  wire en_b2  = slot_assign_control_q[`TSA_B_EN_B2];
  wire en_d   = slot_assign_control_q[`TSA_B_EN_D];
  wire m4src  = slot_assign_control_q[`TSA_B_M4SRC];
  wire dport  = config_two_register_q[`TSA_B_DPORT] & host_mode_pin_i;
  wire tsa    = en_b1 | en_b2 | en_d;
  wire gcibus = host_mode_pin_i & slot_assign_control_q[`TSA_B_GCI];
  wire fsync  = gcibus ? s2_q[2] : s2_q[3];
  wire bc_rise = s2_q[4] & ~bclk_prev_q;
  wire bc_fall = ~s2_q[4] & bclk_prev_q;
  wire fs_rise = fsync & ~fs_prev_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_q        <= 6'h00;
      s2_q        <= 6'h00;
      bclk_prev_q <= 1'b0;
      fs_prev_q   <= 1'b0;
    end else begin
      s1_q        <= pins;
      s2_q        <= s1_q;
      bclk_prev_q <= s2_q[4];
      fs_prev_q   <= fsync;
    end
  end

  // ----------------------------------------
  // Slot counter: a slot is two bit clocks
  // ----------------------------------------
  // Steps on the falling edge so a bit keeps its slot for output and input
  reg       half_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      slot_cnt_q <= 8'h00;
      half_q     <= 1'b0;
    end else if (fs_rise) begin
      slot_cnt_q <= 8'h00;
      half_q     <= 1'b0;
    end else if (bc_fall) begin
      half_q <= ~half_q;
      if (half_q == `TSA_BITS_PER_SLOT)
        slot_cnt_q <= slot_cnt_q + 8'h01;
    end
  end

  // Slot where a channel window opens, and its last slot offset (width in slots less one)
  function in_window;
    input [7:0] cnt;
    input [7:0] start;
    input [2:0] len;
    begin
      in_window = (cnt >= start) && ((cnt - start) <= {5'h00, len});
    end
  endfunction

  // Field_a field decoded like the three slot pins: each step is 4 timeslots
  wire [2:0] gslot = in_d_and_field_a_q[`TSA_B_GSLOT_HI:0];
  wire [7:0] gbase = {3'h0, gslot, 2'h0};

  // Channel windows: B 8 bits (4 slots), D 2 bits (1 slot)
  // Without the assigner the default placement follows the Field_a, else the slot registers
  wire [7:0] ob1 = tsa ? out_b1_slot_q : gbase;
  wire [7:0] ob2 = tsa ? out_b2_slot_q : gbase + `TSA_FIELD_A_W;
  wire [7:0] od  = tsa ? out_d_slot_q  : gbase + `TSA_FIELD_A_W + `TSA_FIELD_A_W;
  wire [7:0] ib1 = tsa ? in_b1_slot_q  : gbase;
  wire [7:0] ib2 = tsa ? in_b2_slot_q  : gbase + `TSA_FIELD_A_W;
  wire [7:0] id  = tsa ? in_d_and_field_a_q : gbase + `TSA_FIELD_A_W + `TSA_FIELD_A_W;

  wire w_ob1 = in_window(slot_cnt_q, ob1, 3'h3) & (en_b1 | ~tsa);
  wire w_ob2 = in_window(slot_cnt_q, ob2, 3'h3) & (en_b2 | ~tsa);
  wire w_od  = in_window(slot_cnt_q, od, 3'h0) & (en_d | (~tsa & ~dport));
  wire w_ib1 = in_window(slot_cnt_q, ib1, 3'h3);
  wire w_ib2 = in_window(slot_cnt_q, ib2, 3'h3);
  wire w_id  = in_window(slot_cnt_q, id, 3'h0);
  wire w_dp  = in_window(slot_cnt_q, od, 3'h0) & dport;
  // Monitor and C/I slots fall outside every window, so stay undriven and unread

  // ----------------------------------------
  // Bit shifting
  // ----------------------------------------
  reg [7:0] rb1_q, rb2_q;
  reg [1:0] rd_q, pd_q;
  // Bit position inside each B window, MSB first
  wire [7:0] off1 = slot_cnt_q - ob1;
  wire [7:0] off2 = slot_cnt_q - ob2;
  wire [2:0] pos1 = {off1[1:0], half_q};
  wire [2:0] pos2 = {off2[1:0], half_q};

  always @(posedge clk_i) begin
    if (rst_i) begin
      serial_dout_o     <= 1'b1;
      serial_dout_oe_o  <= 1'b0;
      dport_data_out_o  <= 1'b1;
      dport_clock_out_o <= 1'b0;
      rb1_q <= 8'hff;
      rb2_q <= 8'hff;
      rd_q  <= 2'h3;
      pd_q  <= 2'h3;
    end else begin
      if (bc_rise) begin
        serial_dout_oe_o <= w_ob1 | w_ob2 | w_od;
        serial_dout_o    <= w_ob1 ? line_b1_rx_i[3'h7 - pos1] :
                            w_ob2 ? line_b2_rx_i[3'h7 - pos2] :
                            w_od  ? line_d_rx_i[~half_q] : 1'b1;
        dport_data_out_o <= w_dp ? line_d_rx_i[~half_q] : 1'b1;
        dport_clock_out_o <= w_dp;
      end
      if (bc_fall) begin
        dport_clock_out_o <= 1'b0;
        if (w_ib1) rb1_q <= {rb1_q[6:0], s2_q[1]};
        if (w_ib2) rb2_q <= {rb2_q[6:0], s2_q[1]};
        if (w_id)  rd_q  <= {rd_q[0], s2_q[1]};
        if (w_dp)  pd_q  <= {pd_q[0], s2_q[5]};
      end
    end
  end

  // ----------------------------------------
  // Line-side data updated at frame start, M4 bits every clock
  // ----------------------------------------
  reg [7:0] m4_d;
  always @* begin
    if (m4src) begin
      m4_d = m4_transmit_register_q;
    end else if (lt_mode_i) begin
      m4_d = {ci_act_i, ci_dea_i, ci_uoa_i, m4_transmit_register_q[4:0]};
    end else begin
      m4_d = {ci_act_i, ci_sai_i, power_status_in_one_i, power_status_in_two_i,
              m4_transmit_register_q[3:0]};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      line_b1_tx_o          <= 8'hff;
      line_b2_tx_o          <= 8'hff;
      line_d_tx_o           <= 2'h3;
      m4_tx_bits_o          <= 8'h00;
      tx_superframe_start_o <= 1'b0;
      assign_mode_o         <= 1'b0;
      field_a_o            <= 8'h00;
    end else begin
      tx_superframe_start_o <= gcibus ? fs_rise : s2_q[0];
      assign_mode_o         <= tsa;
      field_a_o            <= gbase;
      m4_tx_bits_o          <= m4_d;
      if (fs_rise) begin
        line_b1_tx_o <= (tsa & ~en_b1) ? 8'hff : rb1_q;
        line_b2_tx_o <= (tsa & ~en_b2) ? 8'hff : rb2_q;
        line_d_tx_o  <= dport ? pd_q : ((tsa & ~en_d) ? 2'h3 : rd_q);
      end
    end
  end

endmodule // tsa_timeslot_assigner

// ===== sim/tsa_checker_asserts.sv
/*
  Port checker for the timeslot assigner.
  Assumes one clock domain and a bind to the design top.
*/
`timescale 1ns/1ps

module tsa_checker (
  // Watched ports
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       soft_rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       serial_bit_clock_i,
  input wire logic       serial_dout_o,
  input wire logic       dport_clock_out_o,
  input wire logic       host_mode_pin_i,
  input wire logic       assign_mode_o,
  input wire logic [7:0] line_b1_tx_o,
  input wire logic [7:0] m4_tx_bits_o
);
  // ----------------------------------------
  // Helper: cycles since the raw bit clock rose
  // ----------------------------------------
  logic [3:0] since_q;
  logic       bclk_q;
  always @(posedge clk_i) begin
    bclk_q <= serial_bit_clock_i;
    if (rst_i || (serial_bit_clock_i && !bclk_q))
      since_q <= 4'h0;
    else if (since_q != 4'hf)
      since_q <= since_q + 4'h1;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  ack_follows_a: assert property (s_req |=> s_pulse) else $error("ack late");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  reset_vals_a: assert property ($past(rst_i) |-> serial_dout_o && line_b1_tx_o == 8'hff &&
    m4_tx_bits_o == 8'h00 && !assign_mode_o) else $error("bad reset value");
  soft_clear_a: assert property (soft_rst_i |-> ##[1:3] !assign_mode_o) else $error("soft reset");
  dclk_width_a: assert property ($rose(dport_clock_out_o) |->
    dport_clock_out_o [*3] ##[1:3] !dport_clock_out_o) else $error("port clock width");
  dport_gate_a: assert property ((!host_mode_pin_i) [*4] |-> !dport_clock_out_o) else $error("port clock");
  dout_timing_a: assert property ($changed(serial_dout_o) && !$past(soft_rst_i) |->
    since_q inside {[1:7]}) else $error("output off bit edge");
endmodule // tsa_checker

bind tsa_timeslot_assigner tsa_checker chk_u (
  .clk_i, .rst_i, .soft_rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .serial_bit_clock_i,
  .serial_dout_o, .dport_clock_out_o, .host_mode_pin_i, .assign_mode_o, .line_b1_tx_o, .m4_tx_bits_o
);

// ===== sim/tsa_serial_partner.sv
/*
  Far end of the serial 2B+D bus: bit clock, frame sync, input data.
  Assumes the design marks its driven bits with an output enable.
*/
`timescale 1ns/1ps

module tsa_serial_partner (
  // Design side
  input  wire logic clk_i,
  input  wire logic dout_i,
  input  wire logic dout_oe_i,
  input  wire logic dclk_i,
  // Bus side
  output logic      bclk_o,
  output logic      fs_o,
  output logic      din_o
);
  logic [31:0] tx_bits = '1;
  logic [31:0] rx_bits;
  logic [31:0] dclk_seen;
  int          bit_no = -1;

  initial begin
    bclk_o = 1'b0;
    fs_o = 1'b0;
    din_o = 1'b0;
  end

  // Idle data toggles so a stale level never passes for data
  always @(posedge clk_i) begin
    if (bit_no < 0)
      din_o <= ~din_o;
    else if (dclk_i)
      dclk_seen[bit_no] <= 1'b1;
  end

  // ----------------------------------------
  // One frame; bit clock stands still between frames
  // ----------------------------------------
  task run_frame();
    #37;
    dclk_seen = '0;
    fs_o = 1'b1;
    #200;
    for (int i = 0; i < 32; i++) begin
      bit_no = i;
      bclk_o = 1'b1;
      din_o = tx_bits[i];
      #400;
      bclk_o = 1'b0;
      fs_o = 1'b0;
      rx_bits[i] = dout_oe_i ? dout_i : 1'bz;
      #400;
    end
    bit_no = -1;
  endtask
endmodule // tsa_serial_partner

// ===== sim/tsa_timeslot_assigner_tb.sv
/*
  Self-checking bench for the timeslot assigner.
  Assumes the serial partner model and the bound checker.
*/
`timescale 1ns/1ps

module tsa_timeslot_assigner_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        soft_rst_i = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, mwr = 1'b0, mval = 1'b0, dpi = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0, rdat, got;
  logic [7:0]  pins = 8'h80;
  logic [7:0]  rb1 = 8'ha5, rb2 = 8'h3c, lb1, lb2, m4, gslot;
  logic [1:0]  rd2 = 2'b10, ld;
  logic        ack, bclk, fs, din, dout, oe, dclk, amode;
  logic [7:0]  slots [6] = '{8'h02, 8'h07, 8'h0c, 8'h01, 8'h05, 8'h0b};
  int          num_errors = 0, checks = 0, cycles = 0;

  always #50 clk_i = ~clk_i;

  tsa_timeslot_assigner dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_bit_clock_i(bclk), .receive_frame_sync_i(fs), .gci_frame_sync_i(fs), .serial_din_i(din),
    .serial_dout_o(dout), .serial_dout_oe_o(oe), .dport_data_in_i(dpi), .dport_data_out_o(),
    .dport_clock_out_o(dclk), .host_mode_pin_i(pins[7]), .lt_mode_i(pins[6]), .tx_superframe_align_in_i(1'b0),
    .power_status_in_one_i(pins[5]), .power_status_in_two_i(pins[4]), .ci_act_i(pins[3]),
    .ci_dea_i(pins[2]), .ci_uoa_i(pins[1]), .ci_sai_i(pins[0]), .mon_m4src_wr_i(mwr),
    .mon_m4src_val_i(mval), .line_b1_rx_i(rb1), .line_b2_rx_i(rb2), .line_d_rx_i(rd2),
    .line_b1_tx_o(lb1), .line_b2_tx_o(lb2), .line_d_tx_o(ld), .m4_tx_bits_o(m4),
    .tx_superframe_start_o(), .assign_mode_o(amode), .field_a_o(gslot));

  tsa_serial_partner p_u (.clk_i(clk_i), .dout_i(dout), .dout_oe_i(oe), .dclk_i(dclk),
    .bclk_o(bclk), .fs_o(fs), .din_o(din));

  // ----------------------------------------
  // Bench plumbing
  // ----------------------------------------
  task complete_run();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      complete_run();
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Master holds the request until ack is sampled, then idles one cycle
  task wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task rd(input logic [5:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(got, {24'h0, e});
  endtask

  task rd_zero();
    for (int i = 0; i < 8; i++)
      rd(6'(i * 4), 8'h00);
  endtask

  task frames(input int n);
    repeat (n) p_u.run_frame();
    @(posedge clk_i);
  endtask

  task put(input int p, input logic [7:0] v, input int n);
    for (int k = 0; k < n; k++)
      p_u.tx_bits[p + k] = v[7 - k];
  endtask

  function automatic logic [7:0] field(input int p, input int n);
    logic [7:0] v;
    v = 8'h00;
    for (int k = 0; k < n; k++)
      v[7 - k] = p_u.rx_bits[p + k];
    return v;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs();
    wb(1'b1, 6'h00, 8'h55);
    rd(6'h00, 8'h00);
    wb(1'b1, 6'h20, 8'h01);
    rd_zero();
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, 6'(i * 4), 8'(8'hc3 ^ i));
      rd(6'(i * 4), 8'(8'hc3 ^ i));
    end
    rd(6'h3c, 8'h00);
  endtask

  task t_assign();
    for (int i = 0; i < 6; i++)
      wb(1'b1, 6'(i * 4), slots[i]);
    wb(1'b1, 6'h18, 8'he0);
    put(2, 8'h96, 8);
    put(10, 8'h5a, 8);
    put(22, 8'h40, 2);
    frames(2);
    chk(field(4, 8), 8'ha5);
    chk(field(14, 8), 8'h3c);
    chk(field(24, 2), 8'h80);
    chk(lb1, 8'h96);
    chk(lb2, 8'h5a);
    chk(ld, 2'b01);
    chk(amode, 1'b1);
  endtask

  // Only B1 enabled: the others leave the bus and feed ones to the line
  task t_disable();
    wb(1'b1, 6'h18, 8'h80);
    frames(2);
    chk(field(4, 8), 8'ha5);
    chk(field(14, 8), 8'hzz);
    chk(lb2, 8'hff);
    chk(ld, 2'b11);
  endtask

  task t_dport();
    wb(1'b1, 6'h1c, 8'h01);
    wb(1'b1, 6'h18, 8'he0);
    frames(2);
    chk(field(24, 2), 8'h80);
    chk(ld, 2'b00);
    chk(p_u.dclk_seen, 32'h0300_0000);
    wb(1'b1, 6'h18, 8'h80);
    frames(1);
    chk(field(24, 8), 8'hzz);
    chk(p_u.dclk_seen, 32'h0300_0000);
    wb(1'b1, 6'h1c, 8'h00);
  endtask

  task t_gci();
    wb(1'b1, 6'h18, 8'h08);
    for (int f = 0; f < 8; f++) begin
      wb(1'b1, 6'h14, 8'(f));
      repeat (2) @(posedge clk_i);
      chk(gslot, 8'(f * 4));
    end
    wb(1'b1, 6'h14, 8'h02);
    frames(1);
    chk(field(16, 8), 8'ha5);
  endtask

  task t_m4();
    pins <= 8'h4a;
    repeat (8) @(posedge clk_i);
    chk(m4[7:5], 3'b101);
    pins <= 8'h21;
    repeat (8) @(posedge clk_i);
    chk(m4[7:4], 4'b0110);
    wb(1'b1, 6'h24, 8'h3c);
    mwr <= 1'b1;
    mval <= 1'b1;
    @(posedge clk_i);
    mwr <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(m4, 8'h3c);
    pins <= 8'h80;
    repeat (8) @(posedge clk_i);
    rd(6'h18, 8'h18);
  endtask

  task t_soft();
    wb(1'b1, 6'h18, 8'he0);
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(amode, 1'b0);
    rd(6'h00, 8'h00);
    wb(1'b1, 6'h20, 8'h01);
    rd_zero();
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_assign();
    t_disable();
    t_dport();
    t_gci();
    t_m4();
    t_soft();
    complete_run();
  end
endmodule // tsa_timeslot_assigner_tb
